// [hw/monitor_slice.sv]
`timescale 1ns/1ps
`default_nettype none

module monitor_slice
   import usage_monitor_pkg::*;
#(
   parameter bit ZAS_EN = 1'b0
) (
   // clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // storage traffic
   input  wire logic        alloc_valid,
   input  wire logic [15:0] alloc_pid,
   input  wire logic [7:0]  alloc_pmg,
   input  wire logic        free_valid,
   input  wire logic [15:0] free_pid,
   input  wire logic [7:0]  free_pmg,
   // register writes
   input  wire logic        flt_wr,
   input  wire logic        ctl_wr,
   input  wire logic        val_wr,
   input  wire logic        snap_wr,
   input  wire logic [31:0] wdata,
   input  wire logic        capture,
   // read views
   output logic [31:0]      rd_flt,
   output logic [31:0]      rd_ctl,
   output logic [31:0]      rd_val,
   output logic [31:0]      rd_snap,
   output logic [2:0]       capsel,
   output logic             irq_req
);

   typedef struct packed {
      logic [15:0]         pid;
      logic [7:0]          perf_monitor_group;
      logic                m_pid;
      logic                m_pmg;
      logic                hold;
      logic                irq_en;
      logic                wrap;
      logic                zas;
      logic [2:0]          capsel;
      logic [VALUE_W-1:0]  value;
      logic                not_ready_flag;
      logic [SETTLE_W-1:0] settle;
      logic [VALUE_W-1:0]  snap_val;
      logic                snap_not_ready_flag;
   } slice_st_t;

   slice_st_t q;
   slice_st_t d;
   logic      inc;
   logic      dec;

   function automatic logic hit(input logic [15:0] p, input logic [7:0] g,
                                input slice_st_t s);
      hit = (!s.m_pid || p == s.pid) && (!s.m_pmg || g == s.perf_monitor_group);
   endfunction

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      inc = alloc_valid && hit(alloc_pid, alloc_pmg, q);
      dec = free_valid && hit(free_pid, free_pmg, q);
      // with hold set, frozen after the wrapping count; value then reads 0
      if (!(q.wrap && q.hold)) begin
         if (inc && !dec) begin
            d.value = q.value + 1'b1;
            if (&q.value) begin
               d.wrap = 1'b1;
            end
         end else if (dec && !inc && q.value != '0) begin
            d.value = q.value - 1'b1;
         end
      end
      // settle countdown owned by this instance alone
      if (q.settle != '0) begin
         d.settle = q.settle - 1'b1;
         if (q.settle == SETTLE_W'(1)) begin
            d.not_ready_flag = 1'b0;
         end
      end
      if (val_wr) begin
         d.not_ready_flag = wdata[NOT_READY_FLAG_BIT];
         d.settle = wdata[NOT_READY_FLAG_BIT] ? SETTLE_LOAD : '0;
      end
      if (flt_wr) begin
         d.pid = wdata[PID_LSB+:16];
         d.perf_monitor_group = wdata[PMG_LSB+:8];
         d.not_ready_flag = 1'b1;
         d.settle = SETTLE_LOAD;
      end
      if (ctl_wr) begin
         d.m_pid = wdata[MATCH_PID];
         d.m_pmg = wdata[MATCH_PMG];
         d.hold = wdata[HOLD_BIT];
         d.irq_en = wdata[IRQ_EN_BIT];
         d.capsel = wdata[CAPSEL_LSB+:3];
         d.zas = ZAS_EN && wdata[ZAS_BIT];
         d.not_ready_flag = 1'b1;
         d.settle = SETTLE_LOAD;
         // only a 0 clears; a wrap in this same cycle still sets it
         if (!wdata[WRAP_BIT] && !(d.wrap && !q.wrap)) begin
            d.wrap = 1'b0;
         end
      end
      if (snap_wr) begin
         d.snap_not_ready_flag = wdata[NOT_READY_FLAG_BIT];
      end
      // one-cycle copy, no handshake; snap_val held until next capture, its flag also changed by a snap write
      if (capture) begin
         d.snap_val = q.value;
         d.snap_not_ready_flag = q.not_ready_flag;
         if (q.zas) begin
            d.value = '0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign rd_flt  = {8'h00, q.perf_monitor_group, q.pid};
   assign rd_ctl  = {1'b0, q.capsel, q.zas, q.wrap, q.irq_en, q.hold, 6'h00,
                     q.m_pmg, q.m_pid, 8'h00, MON_TYPE};
   assign rd_val  = {q.not_ready_flag, q.value};
   assign rd_snap = {q.snap_not_ready_flag, q.snap_val};
   assign capsel  = q.capsel;
   assign irq_req = q.wrap && q.irq_en;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_snap_load: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && capture) |=> (q.snap_val == $past(q.value) && q.snap_not_ready_flag == $past(q.not_ready_flag)))
      else $error("snapshot did not take the live value");

   a_wrap_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.wrap && !(ce && ctl_wr && !wdata[WRAP_BIT])) |=> q.wrap)
      else $error("wrap flag dropped without a zero write");

   a_cfg_not_ready_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && flt_wr) |=> (q.not_ready_flag && q.settle == SETTLE_LOAD))
      else $error("filter write did not raise not ready");

   a_settle_end: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && q.settle == SETTLE_W'(1) && !flt_wr && !ctl_wr && !val_wr) |=> !q.not_ready_flag)
      else $error("not ready outlived its settle time");

   a_hold_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
      (q.wrap && q.hold && !ctl_wr && !capture) |=> q.value == $past(q.value))
      else $error("held counter moved after wrap");

   a_zero_after: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && capture && q.zas) |=> q.value == '0)
      else $error("count not cleared after snapshot");

endmodule

`default_nettype wire

// [hw/usage_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module usage_monitor
   import usage_monitor_pkg::*;
#(
   parameter int              NUM_MON               = 4,
   parameter bit              LOCAL_TRIGGER_PRESENT = 1'b1,
   parameter logic [NUM_MON-1:0] SECURE_MASK        = '0,
   parameter bit              ZAS_EN                = 1'b0
) (
   // clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // storage allocation events, same clock
   input  wire logic        alloc_valid,
   input  wire logic [15:0] alloc_partition_id,
   input  wire logic [7:0]  alloc_perf_monitor_group,
   input  wire logic        free_valid,
   input  wire logic [15:0] free_partition_id,
   input  wire logic [7:0]  free_perf_monitor_group,
   // external capture sources 0..6, asynchronous
   input  wire logic [6:0]  ext_capture,
   // overflow interrupt
   output logic             wrap_irq
);

   localparam int IDX_W = (NUM_MON > 1) ? $clog2(NUM_MON) : 1;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [IDX_W-1:0] sel;
      logic [7:0]       addr;
      logic             wr;
      logic [31:0]      rdata;
      logic             ready;
      logic [6:0]       sync_a;
      logic [6:0]       sync_b;
      logic [6:0]       sync_c;
      logic             lt_ns;
      logic             lt_s;
      logic             lt_all;
      logic             irq;
   } top_st_t;

   top_st_t q;
   top_st_t d;

   logic               addr_ph;
   logic [6:0]         ext_edge;
   logic [NUM_MON-1:0] flt_wr;
   logic [NUM_MON-1:0] ctl_wr;
   logic [NUM_MON-1:0] val_wr;
   logic [NUM_MON-1:0] snap_wr;
   logic [NUM_MON-1:0] capture;
   logic [NUM_MON-1:0] irq_req;
   logic [31:0]        rd_flt  [NUM_MON];
   logic [31:0]        rd_ctl  [NUM_MON];
   logic [31:0]        rd_val  [NUM_MON];
   logic [31:0]        rd_snap [NUM_MON];
   logic [2:0]         capsel  [NUM_MON];

   function automatic logic reg_is(input logic [7:0] a, input logic [7:0] off);
      reg_is = (a == off);
   endfunction

   // ------------------------------------------------------------------
   // per-instance write strobes and capture routing
   // ------------------------------------------------------------------
   // strobes reach only the selected instance
   for (genvar i = 0; i < NUM_MON; i++) begin : g_route
      logic here;
      logic local_hit;
      assign here = q.wr && (q.sel == IDX_W'(i));
      assign flt_wr[i]  = here && reg_is(q.addr, OFF_FILTER);
      assign ctl_wr[i]  = here && reg_is(q.addr, OFF_CONTROL);
      assign val_wr[i]  = here && reg_is(q.addr, OFF_VALUE);
      assign snap_wr[i] = here && reg_is(q.addr, OFF_SNAP);
      // registered pulses: lt_all feeds every instance, lt_s only secure ones, lt_ns only non-secure ones
      assign local_hit = q.lt_all || (SECURE_MASK[i] ? q.lt_s : q.lt_ns);
      assign capture[i] = (capsel[i] == SRC_LOCAL) ? local_hit
                                                    : ext_edge[capsel[i]];

      monitor_slice #(
         .ZAS_EN (ZAS_EN)
      ) u_slice (
         .hclk        (hclk),
         .hresetn     (hresetn),
         .ce          (ce),
         .alloc_valid (alloc_valid),
         .alloc_pid   (alloc_partition_id),
         .alloc_pmg   (alloc_perf_monitor_group),
         .free_valid  (free_valid),
         .free_pid    (free_partition_id),
         .free_pmg    (free_perf_monitor_group),
         .flt_wr      (flt_wr[i]),
         .ctl_wr      (ctl_wr[i]),
         .val_wr      (val_wr[i]),
         .snap_wr     (snap_wr[i]),
         .wdata       (hwdata),
         .capture     (capture[i]),
         .rd_flt      (rd_flt[i]),
         .rd_ctl      (rd_ctl[i]),
         .rd_val      (rd_val[i]),
         .rd_snap     (rd_snap[i]),
         .capsel      (capsel[i]),
         .irq_req     (irq_req[i])
      );
   end

   // ------------------------------------------------------------------
   // bus, triggers and synchronisers
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      addr_ph = hsel && htrans[1] && hready;
      ext_edge = q.sync_b & ~q.sync_c;
      d.sync_a = ext_capture;
      d.sync_b = q.sync_a;
      d.sync_c = q.sync_b;
      d.ready = 1'b1;
      d.wr = addr_ph && hwrite;
      if (addr_ph) begin
         d.addr = haddr[7:0];
      end
      d.lt_ns = 1'b0;
      d.lt_s = 1'b0;
      d.lt_all = 1'b0;
      if (q.wr) begin
         if (reg_is(q.addr, OFF_SEL)) begin
            d.sel = hwdata[IDX_W-1:0];
         end
         // absent generator swallows fire writes
         if (LOCAL_TRIGGER_PRESENT) begin
            if (reg_is(q.addr, OFF_TRIG_NS)) begin
               d.lt_ns = hwdata[FIRE_BIT];
            end
            if (reg_is(q.addr, OFF_TRIG_S)) begin
               d.lt_s = hwdata[FIRE_BIT] && !hwdata[ALL_BIT];
               d.lt_all = hwdata[FIRE_BIT] && hwdata[ALL_BIT];
            end
         end
      end
      // read data sampled in the address phase, so a read straight
      // behind a write to the same instance still sees the old value
      if (addr_ph && !hwrite) begin
         unique case (haddr[7:0])
            OFF_SEL:     d.rdata = 32'(q.sel);
            OFF_FILTER:  d.rdata = rd_flt[q.sel];
            OFF_CONTROL: d.rdata = rd_ctl[q.sel];
            OFF_VALUE:   d.rdata = rd_val[q.sel];
            OFF_SNAP:    d.rdata = rd_snap[q.sel];
            OFF_ID:      d.rdata = {16'(NUM_MON), 15'h0000, LOCAL_TRIGGER_PRESENT};
            default:     d.rdata = RDATA_RESET;
         endcase
      end
      d.irq = |irq_req;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{ready: 1'b1, rdata: RDATA_RESET, default: '0};
      end else if (ce) begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign hreadyout = q.ready;
   assign hrdata    = q.rdata;
   assign hresp     = 1'b0;
   assign wrap_irq  = q.irq;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_ns_fire: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && LOCAL_TRIGGER_PRESENT && q.wr && q.addr == OFF_TRIG_NS && hwdata[FIRE_BIT])
      |=> (q.lt_ns && !q.lt_s && !q.lt_all))
      else $error("non-secure fire write gave no non-secure pulse");

   a_s_only: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && LOCAL_TRIGGER_PRESENT && q.wr && q.addr == OFF_TRIG_S
       && hwdata[FIRE_BIT] && !hwdata[ALL_BIT]) |=> (q.lt_s && !q.lt_all && !q.lt_ns))
      else $error("secure fire leaked outside secure space");

   a_no_local: assert property (@(posedge hclk) disable iff (!hresetn)
      !LOCAL_TRIGGER_PRESENT |-> !(q.lt_ns || q.lt_s || q.lt_all))
      else $error("local capture without a generator");

   a_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && (|irq_req)) |=> wrap_irq)
      else $error("wrap interrupt not raised");

endmodule

`default_nettype wire

// [hw/usage_monitor_pkg.sv]
package usage_monitor_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SETTLE_TIME_US = 20;
   localparam int SETTLE_CYCLES = SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_CYCLES[SETTLE_W-1:0];

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_SEL     = 8'h00;
   localparam logic [7:0] OFF_FILTER  = 8'h04;
   localparam logic [7:0] OFF_CONTROL = 8'h08;
   localparam logic [7:0] OFF_VALUE   = 8'h0c;
   localparam logic [7:0] OFF_SNAP    = 8'h10;
   localparam logic [7:0] OFF_TRIG_NS = 8'h14;
   localparam logic [7:0] OFF_TRIG_S  = 8'h18;
   localparam logic [7:0] OFF_ID      = 8'h1c;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int PID_LSB      = 0;
   localparam int PMG_LSB      = 16;
   localparam int MATCH_PID    = 16;
   localparam int MATCH_PMG    = 17;
   localparam int HOLD_BIT     = 24;
   localparam int IRQ_EN_BIT   = 25;
   localparam int WRAP_BIT     = 26;
   localparam int ZAS_BIT      = 27;
   localparam int CAPSEL_LSB   = 28;
   localparam int NOT_READY_FLAG_BIT     = 31;
   localparam int FIRE_BIT     = 0;
   localparam int ALL_BIT      = 1;
   localparam int NUM_MON_LSB  = 16;

   // ------------------------------------------------------------------
   // constants and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]  MON_TYPE     = 8'h43;
   localparam logic [2:0]  SRC_LOCAL    = 3'h7;
   localparam int          VALUE_W      = 31;
   localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

endpackage

// [tb/tb_usage_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_usage_monitor;
   import usage_monitor_pkg::*;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        hclk;
   logic        hresetn;
   logic        ce;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   wire  logic  hreadyout;
   wire  logic [31:0] hrdata;
   wire  logic  hresp;
   wire  logic  wrap_irq;
   logic        alloc_valid;
   logic [15:0] alloc_pid;
   logic [7:0]  alloc_pmg;
   logic        free_valid;
   logic [15:0] free_pid;
   logic [7:0]  free_pmg;
   logic [6:0]  ext_capture;
   logic        rd_pending;
   logic [31:0] exp_q[$];
   logic [31:0] mask_q[$];
   logic [30:0] cnt[4];
   logic [31:0] sexp[4];
   logic [31:0] seed;
   int          n_mismatch;
   int          n_compared;
   int          cyc;

   // secure instances 0 and 1, non-secure 2 and 3
   usage_monitor #(.NUM_MON(4), .LOCAL_TRIGGER_PRESENT(1'b1), .SECURE_MASK(4'b0011),
                   .ZAS_EN(1'b0)) DUT (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .alloc_valid(alloc_valid), .alloc_partition_id(alloc_pid),
      .alloc_perf_monitor_group(alloc_pmg), .free_valid(free_valid),
      .free_partition_id(free_pid), .free_perf_monitor_group(free_pmg),
      .ext_capture(ext_capture), .wrap_irq(wrap_irq));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // read data leaves the queue in the data phase
   always @(posedge hclk) begin
      if (rd_pending === 1'b1 && hreadyout === 1'b1) begin
         check_word("hrdata", exp_q.pop_front(), hrdata & mask_q.pop_front());
      end
   end

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      if (!w) begin
         exp_q.push_back(e & m);
         mask_q.push_back(m);
      end
      rd_pending <= !w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_pending <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      ahb(a, 1'b0, 32'h0, e, m);
   endtask

   // random storage traffic with the expected counts kept alongside
   task automatic traffic(input int n);
      logic [15:0] pid;
      logic [7:0]  perf_monitor_group;
      repeat (n) begin
         @(posedge hclk);
         seed = xs(seed);
         pid = seed[3] ? 16'(seed[1:0]) + 16'h1 : seed[19:4];
         perf_monitor_group = 8'h10 + 8'(seed[1:0]) ^ (seed[2] ? 8'h80 : 8'h0);
         alloc_valid <= seed[5];
         free_valid <= !seed[5] && seed[6];
         alloc_pid <= pid;
         free_pid <= pid;
         alloc_pmg <= perf_monitor_group;
         free_pmg <= perf_monitor_group;
         ext_capture[6:1] <= seed[31:26];
         for (int i = 0; i < 4; i++) begin
            if (pid == 16'(i + 1) && perf_monitor_group == 8'(8'h10 + i)) begin
               if (seed[5]) begin
                  cnt[i]++;
               end else if (seed[6] && cnt[i] != 31'h0) begin
                  cnt[i]--;
               end
            end
         end
      end
      @(posedge hclk);
      alloc_valid <= 1'b0;
      free_valid <= 1'b0;
   endtask

   function automatic void capture(input logic [3:0] m);
      for (int i = 0; i < 4; i++) begin
         if (m[i]) begin
            sexp[i] = {1'b0, cnt[i]};
         end
      end
   endfunction

   task automatic check_all;
      for (int i = 0; i < 4; i++) begin
         wr(OFF_SEL, 32'(i));
         rd(OFF_VALUE, {1'b0, cnt[i]}, 32'hffff_ffff);
         rd(OFF_SNAP, sexp[i], 32'hffff_ffff);
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      alloc_valid = 1'b0;
      alloc_pid = 16'h0;
      alloc_pmg = 8'h0;
      free_valid = 1'b0;
      free_pid = 16'h0;
      free_pmg = 8'h0;
      ext_capture = 7'h0;
      rd_pending = 1'b0;
      seed = 32'h047a4621;
      for (int i = 0; i < 4; i++) begin
         cnt[i] = 31'h0;
         sexp[i] = 32'h0;
      end
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd(OFF_CONTROL, 32'h0000_0043, 32'hffff_ffff);
      rd(OFF_ID, 32'h0004_0001, 32'hffff_ffff);
      rd(8'h20, 32'h0, 32'hffff_ffff);
      // reserved filter bits and bit 27 written as ones must read back zero
      for (int i = 0; i < 4; i++) begin
         wr(OFF_SEL, 32'(i));
         wr(OFF_FILTER, 32'hff00_0000 | (32'(8'h10 + i) << 16) | 32'(i + 1));
         wr(OFF_CONTROL, i == 3 ? 32'h0b03_0000 : 32'h7b03_0000);
         rd(OFF_FILTER, (32'(8'h10 + i) << 16) | 32'(i + 1), 32'hffff_ffff);
         rd(OFF_CONTROL, i == 3 ? 32'h0303_0043 : 32'h7303_0043, 32'hffff_ffff);
         rd(OFF_VALUE, 32'h8000_0000, 32'h8000_0000);
      end
      repeat (SETTLE_CYCLES + 20) @(posedge hclk);
      wr(OFF_SEL, 32'h0);
      wr(OFF_FILTER, 32'h0010_0001);
      rd(OFF_VALUE, 32'h8000_0000, 32'h8000_0000);
      wr(OFF_SEL, 32'h1);
      rd(OFF_VALUE, 32'h0, 32'h8000_0000);
      wr(OFF_SEL, 32'h0);
      repeat (SETTLE_CYCLES - 40) @(posedge hclk);
      rd(OFF_VALUE, 32'h8000_0000, 32'h8000_0000);
      repeat (40) @(posedge hclk);
      rd(OFF_VALUE, 32'h0, 32'h8000_0000);
      traffic(60);
      wr(OFF_TRIG_NS, 32'h1);
      capture(4'b0100);
      check_all();
      traffic(60);
      wr(OFF_TRIG_S, 32'h1);
      capture(4'b0011);
      check_all();
      traffic(60);
      wr(OFF_TRIG_S, 32'h3);
      capture(4'b0111);
      check_all();
      traffic(40);
      // external pin sits behind a two-stage synchroniser
      @(posedge hclk);
      ext_capture[0] <= 1'b1;
      repeat (6) @(posedge hclk);
      capture(4'b1000);
      check_all();
      // allocations offered while the enable is low must not count
      @(posedge hclk);
      ce <= 1'b0;
      alloc_valid <= 1'b1;
      alloc_pid <= 16'h1;
      alloc_pmg <= 8'h10;
      repeat (5) @(posedge hclk);
      alloc_valid <= 1'b0;
      ce <= 1'b1;
      check_all();
      wr(OFF_SEL, 32'h1);
      wr(OFF_VALUE, 32'h8000_0000);
      rd(OFF_VALUE, {1'b1, cnt[1]}, 32'hffff_ffff);
      wr(OFF_TRIG_S, 32'h1);
      rd(OFF_SNAP, {1'b1, cnt[1]}, 32'hffff_ffff);
      wr(OFF_VALUE, 32'h0);
      rd(OFF_VALUE, {1'b0, cnt[1]}, 32'hffff_ffff);
      wr(OFF_SNAP, 32'h0);
      rd(OFF_SNAP, {1'b0, cnt[1]}, 32'hffff_ffff);
      // irq enabled everywhere but nothing overflowed
      check_word("wrap_irq", 32'h0, {31'h0, wrap_irq});
      check_word("hresp", 32'h0, {31'h0, hresp});
      complete_run();
   end

endmodule

`default_nettype wire
